// file: adcss_sequencer.sv
// Purpose: four-sequence sample sequencer with APB registers and result FIFOs
// Assumes: converter logic on clk; trigger inputs may be asynchronous
// Notes:   one conversion in flight at a time; APB answers with no wait state
// How it works
// - four sequences; sequence 0 holds eight steps, 1 and 2 four, 3 one.
// - writing a processor trigger bit starts a sequence set to processor source.
// - a sequence may be triggered by any of three comparator events.
// - a sequence may be triggered by the external port B pin 4 input.
// - a sequence may be triggered by the general-purpose timer output.
// - a sequence may be triggered by any of three PWM generator outputs.
// - always source retriggers continuously unless a higher-priority sequence waits.
// - each sequence holds a 2-bit priority, zero highest, three lowest.
// - a disabled sequence ignores triggers and is never launched; a run already under way still captures.
// - an enabled sequence starts capturing when its selected trigger is seen.
// - results go to a per-sequence FIFO; reads return only written samples.
// - overflow flag sets when a sequence restarts with unread samples.
// - overflow stays set until software clears it; clearing does nothing else.
// - underflow flag sets when software reads an empty FIFO.
// - each step holds differential, input select and temperature select, applied per step.
// - a sequence stops after the step whose last flag is set.
// - a finished step with its interrupt bit set raises the sequence status.
// - step indices are 0-7, 0-3, 0-3 and only 0 per sequence.
// - steps convert in ascending order starting at step zero.
// - differential pair n samples inputs 2n and 2n+1.
// - the highest-priority pending sequence runs first; others may starve.
`timescale 1ns/100ps
module adcss_sequencer (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [adcss_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [2:0]                    trig_comparator,
    input  wire logic                          trig_ext_pin,
    input  wire logic                          trig_timer,
    input  wire logic [2:0]                    trig_pwm,
    output logic                               conv_start,
    output logic                               conv_diff,
    output logic                               conv_temp,
    output logic [2:0]                         conv_pos_in,
    output logic [2:0]                         conv_neg_in,
    input  wire logic                          conv_done,
    input  wire logic [adcss_pkg::RES_W-1:0]   conv_result,
    output logic                               seq_busy
);

    // ==========================================================
    // state
    typedef struct packed {
        adcss_pkg::adcss_state_t                                state;
        logic [1:0]                                             cur;
        logic [2:0]                                             step;
        logic [3:0]                                             enable;
        logic [15:0]                                            trig_sel;
        logic [7:0]                                             prio;
        logic [3:0]                                             pend;
        logic [3:0]                                             ovf;
        logic [3:0]                                             unf;
        logic [3:0]                                             irq_st;
        adcss_pkg::adcss_step_t [adcss_pkg::NUM_STEP-1:0]       steps;
        logic [3:0][adcss_pkg::MAX_CAP-1:0][adcss_pkg::RES_W-1:0] fifo;
        logic [3:0][2:0]                                        rd;
        logic [3:0][3:0]                                        cnt;
        logic [adcss_pkg::NUM_EV-1:0]                           sync1;
        logic [adcss_pkg::NUM_EV-1:0]                           sync2;
        logic [adcss_pkg::NUM_EV-1:0]                           prev;
        logic                                                   conv_start;
        logic                                                   conv_diff;
        logic                                                   conv_temp;
        logic [2:0]                                             conv_pos_in;
        logic [2:0]                                             conv_neg_in;
        logic [31:0]                                            prdata;
    } adcss_regs_t;

    adcss_regs_t                r;
    adcss_regs_t                next_r;
    logic [adcss_pkg::NUM_EV-1:0] ev;
    logic                       wr_acc;
    logic                       rd_acc;
    logic                       setup;
    logic                       is_data;
    logic                       is_cnt;
    logic                       is_step;
    logic                       addr_ok;
    logic [1:0]                 asel;
    logic [4:0]                 sidx;
    logic [3:0]                 set_pend;
    logic [3:0]                 set_ovf;
    logic [3:0]                 set_unf;
    logic [3:0]                 set_irq;
    logic [3:0]                 push;
    logic [3:0]                 pop;
    logic                       launch;
    logic                       better_pend;
    logic [1:0]                 best;
    logic                       found;
    adcss_pkg::adcss_step_t     cfg;
    logic [4:0]                 cfg_idx;
    logic [3:0]                 wpos;
    logic [3:0]                 src;
    logic                       hit;

    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~addr_ok;
    assign prdata     = r.prdata;
    assign conv_start = r.conv_start;
    assign conv_diff  = r.conv_diff;
    assign conv_temp  = r.conv_temp;
    assign conv_pos_in = r.conv_pos_in;
    assign conv_neg_in = r.conv_neg_in;
    assign seq_busy   = (r.state != adcss_pkg::ST_IDLE);

    // ==========================================================
    // next state
    always_comb begin
        next_r = r;
        next_r.conv_start = 1'b0;
        // pins pass two flops before any logic reads them
        next_r.sync1 = {trig_pwm, trig_timer, trig_ext_pin, trig_comparator};
        next_r.sync2 = r.sync1;
        next_r.prev  = r.sync2;
        ev = r.sync2 & ~r.prev;

        wr_acc  = psel & penable & pwrite;
        rd_acc  = psel & penable & ~pwrite;
        setup   = psel & ~penable;
        asel    = paddr[adcss_pkg::SEQ_SEL_LSB +: 2];
        is_data = (paddr & adcss_pkg::SEQ_SEL_MASK) == adcss_pkg::OFS_FIFO_DATA;
        is_cnt  = (paddr & adcss_pkg::SEQ_SEL_MASK) == adcss_pkg::OFS_FIFO_CNT;
        is_step = (paddr >= adcss_pkg::OFS_STEP_BASE) && (paddr <= adcss_pkg::OFS_STEP_LAST)
                  && (paddr[1:0] == 2'h0);
        sidx    = 5'((paddr - adcss_pkg::OFS_STEP_BASE) >> 2);
        addr_ok = is_data | is_cnt | is_step
                  | (paddr == adcss_pkg::OFS_ENABLE)   | (paddr == adcss_pkg::OFS_PROC_TRIG)
                  | (paddr == adcss_pkg::OFS_OVERFLOW) | (paddr == adcss_pkg::OFS_UNDERFLOW)
                  | (paddr == adcss_pkg::OFS_IRQ_STAT) | (paddr == adcss_pkg::OFS_PRIORITY)
                  | (paddr == adcss_pkg::OFS_TRIG_SEL) | (paddr == adcss_pkg::OFS_BUSY);

        set_pend = 4'h0;
        set_ovf  = 4'h0;
        set_unf  = 4'h0;
        set_irq  = 4'h0;
        push     = 4'h0;
        pop      = 4'h0;
        launch   = 1'b0;
        found    = 1'b0;
        best     = 2'h0;
        better_pend = 1'b0;
        src      = 4'h0;
        hit      = 1'b0;
        wpos     = 4'h0;

        // trigger detection per sequence
        for (int s = 0; s < adcss_pkg::NUM_SEQ; s++) begin
            src = r.trig_sel[s*adcss_pkg::TSEL_W +: adcss_pkg::TSEL_W];
            hit = 1'b0;
            if (src == adcss_pkg::trig_src_processor) begin
                hit = wr_acc && (paddr == adcss_pkg::OFS_PROC_TRIG) && pwdata[s];
            end else if (src == adcss_pkg::trig_src_always) begin
                hit = 1'b1;
            end else if (src <= adcss_pkg::trig_src_pwm_third) begin
                // comparators, pin, timer and pwm share one event vector
                hit = ev[3'(src - 4'h1)];
            end
            set_pend[s] = hit & r.enable[s];
        end

        // pick lowest priority value; equal values favour lower number
        for (int s = 0; s < adcss_pkg::NUM_SEQ; s++) begin
            if (r.pend[s] && r.enable[s] && (!found ||
                r.prio[s*adcss_pkg::PRIO_W +: 2] < r.prio[best*adcss_pkg::PRIO_W +: 2])) begin
                found = 1'b1;
                best  = 2'(s);
            end
        end
        for (int s = 0; s < adcss_pkg::NUM_SEQ; s++) begin
            if (r.pend[s] && r.enable[s] &&
                r.prio[s*adcss_pkg::PRIO_W +: 2] < r.prio[best*adcss_pkg::PRIO_W +: 2]) begin
                better_pend = 1'b1;
            end
        end

        cfg_idx = 5'(r.step) + adcss_pkg::SEQ_BASE[r.cur];
        cfg     = r.steps[cfg_idx];

        case (r.state)
            adcss_pkg::ST_IDLE: begin
                if (found) begin
                    launch = 1'b1;
                    next_r.cur  = best;
                    next_r.step = 3'h0;
                    next_r.state = adcss_pkg::ST_START;
                    set_ovf[best] = (r.cnt[best] != 4'h0);
                end
            end
            adcss_pkg::ST_START: begin
                // step settings reach the converter with the start pulse
                next_r.conv_start = 1'b1;
                next_r.conv_diff  = cfg.step_diff_mode;
                next_r.conv_temp  = cfg.step_temp_sensor_sel;
                if (cfg.step_diff_mode) begin
                    next_r.conv_pos_in = {cfg.step_input_sel[1:0], 1'b0};
                    next_r.conv_neg_in = {cfg.step_input_sel[1:0], 1'b1};
                end else begin
                    next_r.conv_pos_in = cfg.step_input_sel;
                    next_r.conv_neg_in = adcss_pkg::STEP_INPUT_SEL_FIRST;
                end
                next_r.state = adcss_pkg::ST_WAIT;
            end
            adcss_pkg::ST_WAIT: begin
                if (conv_done) begin
                    push[r.cur] = 1'b1;
                    set_irq[r.cur] = cfg.step_irq_request;
                    // stop on last flag or at the sequence depth
                    if (cfg.step_last_flag ||
                        (4'(r.step) == adcss_pkg::SEQ_CAP[r.cur] - 4'h1)) begin
                        next_r.state = adcss_pkg::ST_IDLE;
                    end else begin
                        next_r.step  = r.step + 3'h1;
                        next_r.state = adcss_pkg::ST_START;
                    end
                end
            end
            default: begin
                next_r.state = adcss_pkg::ST_IDLE;
            end
        endcase

        // new triggers win over the clear at launch; disabling drops waiting triggers
        next_r.pend = ((r.pend & ~(launch ? (4'h1 << best) : 4'h0)) | set_pend) & r.enable;

        // fifo pop on read access
        if (rd_acc && is_data) begin
            if (r.cnt[asel] == 4'h0) begin
                set_unf[asel] = 1'b1;
            end else begin
                pop[asel] = 1'b1;
            end
        end

        for (int s = 0; s < adcss_pkg::NUM_SEQ; s++) begin
            wpos = 4'(r.rd[s]) + r.cnt[s];
            if (wpos >= adcss_pkg::SEQ_CAP[s]) begin
                wpos = wpos - adcss_pkg::SEQ_CAP[s];
            end
            // a full fifo drops the new sample; overflow already flagged it
            if (push[s] && (r.cnt[s] < adcss_pkg::SEQ_CAP[s] || pop[s])) begin
                next_r.fifo[s][wpos[2:0]] = conv_result;
            end else begin
                push[s] = 1'b0;
            end
            if (pop[s]) begin
                if (4'(r.rd[s]) + 4'h1 == adcss_pkg::SEQ_CAP[s]) begin
                    next_r.rd[s] = 3'h0;
                end else begin
                    next_r.rd[s] = r.rd[s] + 3'h1;
                end
            end
            next_r.cnt[s] = r.cnt[s] + {3'h0, push[s]} - {3'h0, pop[s]};
        end

        // sticky flags: set wins over a same-cycle clear
        next_r.ovf    = (r.ovf & ~((wr_acc && paddr == adcss_pkg::OFS_OVERFLOW)
                        ? pwdata[3:0] : 4'h0)) | set_ovf;
        next_r.unf    = (r.unf & ~((wr_acc && paddr == adcss_pkg::OFS_UNDERFLOW)
                        ? pwdata[3:0] : 4'h0)) | set_unf;
        next_r.irq_st = (r.irq_st & ~((wr_acc && paddr == adcss_pkg::OFS_IRQ_STAT)
                        ? pwdata[3:0] : 4'h0)) | set_irq;

        // configuration writes
        if (wr_acc) begin
            if (paddr == adcss_pkg::OFS_ENABLE) begin
                next_r.enable = pwdata[3:0];
            end
            if (paddr == adcss_pkg::OFS_PRIORITY) begin
                next_r.prio = pwdata[7:0];
            end
            if (paddr == adcss_pkg::OFS_TRIG_SEL) begin
                next_r.trig_sel = pwdata[15:0];
            end
            if (is_step) begin
                next_r.steps[sidx] = pwdata[6:0];
            end
        end

        // read data is captured in the setup cycle so it leaves a flop
        if (setup && !pwrite) begin
            next_r.prdata = 32'h0000_0000;
            if (paddr == adcss_pkg::OFS_ENABLE) begin
                next_r.prdata[3:0] = r.enable;
            end else if (paddr == adcss_pkg::OFS_OVERFLOW) begin
                next_r.prdata[3:0] = r.ovf;
            end else if (paddr == adcss_pkg::OFS_UNDERFLOW) begin
                next_r.prdata[3:0] = r.unf;
            end else if (paddr == adcss_pkg::OFS_IRQ_STAT) begin
                next_r.prdata[3:0] = r.irq_st;
            end else if (paddr == adcss_pkg::OFS_PRIORITY) begin
                next_r.prdata[7:0] = r.prio;
            end else if (paddr == adcss_pkg::OFS_TRIG_SEL) begin
                next_r.prdata[15:0] = r.trig_sel;
            end else if (paddr == adcss_pkg::OFS_BUSY) begin
                next_r.prdata[3:0] = r.pend;
                next_r.prdata[4]   = (r.state != adcss_pkg::ST_IDLE);
            end else if (is_data && r.cnt[asel] != 4'h0) begin
                next_r.prdata[adcss_pkg::RES_W-1:0] = r.fifo[asel][r.rd[asel]];
            end else if (is_cnt) begin
                next_r.prdata[3:0] = r.cnt[asel];
            end else if (is_step) begin
                next_r.prdata[6:0] = r.steps[sidx];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // checks
    sequence s_launch;
        r.state == adcss_pkg::ST_IDLE && launch;
    endsequence

    sequence s_first_step;
        r.state == adcss_pkg::ST_START && r.step == 3'h0 ##1 r.conv_start;
    endsequence

    property p_first_step;
        @(posedge clk) disable iff (!rst_n) s_launch |=> s_first_step;
    endproperty
    a_first_step: assert property (p_first_step) else $error("sequence did not begin at step zero");

    property p_enabled_only;
        @(posedge clk) disable iff (!rst_n) s_launch |-> r.enable[best] && r.pend[best];
    endproperty
    a_enabled_only: assert property (p_enabled_only) else $error("disabled sequence launched");

    property p_priority;
        @(posedge clk) disable iff (!rst_n) s_launch |-> !better_pend;
    endproperty
    a_priority: assert property (p_priority) else $error("lower priority sequence chosen");

    property p_step_advance;
        @(posedge clk) disable iff (!rst_n)
            (r.state == adcss_pkg::ST_WAIT && conv_done && !cfg.step_last_flag
             && 4'(r.step) != adcss_pkg::SEQ_CAP[r.cur] - 4'h1)
            |=> r.step == $past(r.step) + 3'h1 ##1 r.conv_start;
    endproperty
    a_step_advance: assert property (p_step_advance) else $error("steps not in order");

    property p_last_stop;
        @(posedge clk) disable iff (!rst_n)
            (r.state == adcss_pkg::ST_WAIT && conv_done && cfg.step_last_flag)
            |=> r.state == adcss_pkg::ST_IDLE;
    endproperty
    a_last_stop: assert property (p_last_stop) else $error("sequence ran past last step");

    property p_irq_raise;
        @(posedge clk) disable iff (!rst_n)
            (r.state == adcss_pkg::ST_WAIT && conv_done && cfg.step_irq_request)
            |=> r.irq_st[$past(r.cur)];
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("step interrupt not raised");

    property p_ovf_sticky;
        @(posedge clk) disable iff (!rst_n)
            !(wr_acc && paddr == adcss_pkg::OFS_OVERFLOW) |=> (r.ovf & $past(r.ovf)) == $past(r.ovf);
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

    property p_ovf_set;
        @(posedge clk) disable iff (!rst_n) (s_launch and (r.cnt[best] != 4'h0)) |=> r.ovf[$past(best)];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

    property p_unf_set;
        @(posedge clk) disable iff (!rst_n) (rd_acc && is_data && r.cnt[asel] == 4'h0) |=> r.unf[$past(asel)];
    endproperty
    a_unf_set: assert property (p_unf_set) else $error("underflow not flagged");

    property p_depth;
        @(posedge clk) disable iff (!rst_n)
            r.cnt[0] <= 4'h8 && r.cnt[1] <= 4'h4 && r.cnt[2] <= 4'h4 && r.cnt[3] <= 4'h1;
    endproperty
    a_depth: assert property (p_depth) else $error("fifo above sequence depth");

    property p_diff_pair;
        @(posedge clk) disable iff (!rst_n)
            (r.conv_start && r.conv_diff) |-> r.conv_neg_in == r.conv_pos_in + 3'h1 && !r.conv_pos_in[0];
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("differential pair wrong");

endmodule

// file: adcss_pkg.sv
// Purpose: shared constants and types for the sample sequencer
// Assumes: 32-bit APB, 12-bit byte address, 10-bit converter result
// Notes:   register offsets are byte addresses of aligned words
package adcss_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_SEQ  = 4;
    localparam int NUM_STEP = 17;
    localparam int MAX_CAP  = 8;
    localparam int RES_W    = 10;
    localparam int ADDR_W   = 12;
    localparam int NUM_EV   = 8;

    // per-sequence depth and first flat step index
    localparam logic [3:0][3:0] SEQ_CAP  = {4'h1, 4'h4, 4'h4, 4'h8};
    localparam logic [3:0][4:0] SEQ_BASE = {5'h10, 5'h0C, 5'h08, 5'h00};

    // ==========================================================
    // register map
    localparam logic [11:0] OFS_ENABLE    = 12'h000;
    localparam logic [11:0] OFS_PROC_TRIG = 12'h004;
    localparam logic [11:0] OFS_OVERFLOW  = 12'h008;
    localparam logic [11:0] OFS_UNDERFLOW = 12'h00C;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h010;
    localparam logic [11:0] OFS_PRIORITY  = 12'h014;
    localparam logic [11:0] OFS_TRIG_SEL  = 12'h018;
    localparam logic [11:0] OFS_BUSY      = 12'h01C;
    localparam logic [11:0] OFS_FIFO_DATA = 12'h020;
    localparam logic [11:0] OFS_FIFO_CNT  = 12'h030;
    localparam logic [11:0] OFS_STEP_BASE = 12'h040;
    localparam logic [11:0] OFS_STEP_LAST = 12'h080;
    localparam logic [11:0] SEQ_SEL_MASK  = 12'hFF3;
    localparam int          SEQ_SEL_LSB   = 2;

    // field widths inside packed registers
    localparam int PRIO_W = 2;
    localparam int TSEL_W = 4;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        trig_src_processor         = 4'h0,
        trig_src_comparator_first  = 4'h1,
        trig_src_comparator_second = 4'h2,
        trig_src_comparator_third  = 4'h3,
        trig_src_external          = 4'h4,
        trig_src_timer             = 4'h5,
        trig_src_pwm_first         = 4'h6,
        trig_src_pwm_second        = 4'h7,
        trig_src_pwm_third         = 4'h8,
        trig_src_always            = 4'h9
    } adcss_trig_t;

    localparam logic [2:0] STEP_INPUT_SEL_FIRST  = 3'h0;
    localparam logic [2:0] STEP_INPUT_SEL_EIGHTH = 3'h7;

    typedef struct packed {
        logic       step_irq_request;
        logic       step_last_flag;
        logic       step_temp_sensor_sel;
        logic [2:0] step_input_sel;
        logic       step_diff_mode;
    } adcss_step_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b10
    } adcss_state_t;

endpackage

// file: adcss_conv_model.sv
// Purpose: behavioural converter answering the sequencer
// Assumes: one conversion in flight
// Notes:   result encodes the settings applied at start
`timescale 1ns/100ps
module adcss_conv_model #(parameter int DLY = 3) (
    input  wire logic       clk,
    input  wire logic       conv_start,
    input  wire logic       conv_diff,
    input  wire logic       conv_temp,
    input  wire logic [2:0] conv_pos_in,
    input  wire logic [2:0] conv_neg_in,
    output logic            conv_done,
    output logic [9:0]      conv_result
);
    // ==========================================
    // conversion timer
    int cnt = 0;
    initial conv_done = 1'b0;
    initial conv_result = 10'h000;
    always @(posedge clk) begin
        conv_done <= (cnt == 1);
        // data only valid with done, so scramble it otherwise
        conv_result <= (cnt == 1) ? {2'h1, conv_temp, conv_diff, conv_pos_in, conv_neg_in}
                                  : ~conv_result;
        cnt <= conv_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule

// file: adc_sample_sequencer_bench.sv
// Purpose: self-checking bench for the sample sequencer
// Assumes: converter model latency of three cycles
// Notes:   expected data follow the model's result encoding
`timescale 1ns/100ps
module adc_sample_sequencer_bench;
    // ==========================================
    // signals and instances
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, cs, cd, ct, done, busy;
    logic [2:0]  cp, cn;
    logic [9:0]  res;
    logic [7:0]  trg = 8'h00;
    int          num_errors = 0, compares = 0, cyc = 0;
    always #50 clk = ~clk;
    adcss_sequencer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_comparator(trg[2:0]), .trig_ext_pin(trg[3]),
        .trig_timer(trg[4]), .trig_pwm(trg[7:5]), .conv_start(cs), .conv_diff(cd),
        .conv_temp(ct), .conv_pos_in(cp), .conv_neg_in(cn), .conv_done(done),
        .conv_result(res), .seq_busy(busy));
    adcss_conv_model #(.DLY(3)) conv (.clk(clk), .conv_start(cs), .conv_diff(cd),
        .conv_temp(ct), .conv_pos_in(cp), .conv_neg_in(cn), .conv_done(done),
        .conv_result(res));
    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wait_idle();
        // trigger pins need three edges before they show as pending
        repeat (4) @(posedge clk);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, 12'h01C, 32'h0);
            if (rd[4:0] === 5'h00) break;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_proc();
        rdc(12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h040, 32'h0A);
        apb(1'b1, 12'h044, 32'h05);
        apb(1'b1, 12'h048, 32'h70);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, busy}, 32'h1);
        wait_idle();
        chk({31'h0, busy}, 32'h0);
        rdc(12'h030, 32'h3);
        rdc(12'h010, 32'h1);
        rdc(12'h020, 32'h128);
        rdc(12'h020, 32'h165);
        rdc(12'h020, 32'h180);
        rdc(12'h020, 32'h0);
        rdc(12'h00C, 32'h1);
        $display("test proc done");
    endtask
    task automatic t_ovf();
        repeat (2) begin
            apb(1'b1, 12'h004, 32'h1);
            wait_idle();
        end
        rdc(12'h008, 32'h1);
        apb(1'b1, 12'h008, 32'h1);
        rdc(12'h008, 32'h0);
        rdc(12'h030, 32'h6);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h1);
        wait_idle();
        rdc(12'h030, 32'h6);
        $display("test ovf done");
    endtask
    task automatic t_src();
        apb(1'b1, 12'h060, 32'h20);
        for (int s = 1; s < 9; s++) begin
            apb(1'b1, 12'h000, 32'h0);
            apb(1'b1, 12'h018, 32'(s << 4));
            apb(1'b1, 12'h000, 32'h2);
            trg <= 8'h01 << (s - 1);
            repeat (2) @(posedge clk);
            trg <= 8'h00;
            wait_idle();
            rdc(12'h034, 32'h1);
            rdc(12'h024, 32'h100);
        end
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h018, 32'h90);
        apb(1'b1, 12'h000, 32'h2);
        repeat (6) apb(1'b0, 12'h01C, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        rdc(12'h008, 32'h2);
        $display("test src done");
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // main sequence and timeout
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, 12'h014, 32'hE4);
        t_proc();
        t_ovf();
        t_src();
        report_and_stop();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
endmodule
